// ==== inc/tip_pkg.sv ====
package tip_pkg;
   // register offsets (byte addresses, one 16-bit register per word)
   localparam logic [7:0] ADDR_ENABLES = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_FORCE = 8'h08;
   localparam logic [7:0] ADDR_ACCUM_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_COUNTER = 8'h10;
   localparam logic [7:0] ADDR_COMPARE1 = 8'h14;
   localparam logic [7:0] ADDR_ACCUM_COUNT = 8'h24;
   localparam logic [7:0] ADDR_COMPARE_STRIDE = 8'h04;
   // enable register fields
   localparam int EN_SHARED = 15;
   localparam int EN_CMP_LO = 11;
   localparam int EN_CAP_LO = 8;
   localparam int EN_OVF = 7;
   localparam int EN_ACC_OVF = 5;
   localparam int EN_ACC_IN = 4;
   localparam int EN_CLK_OUT = 3;
   localparam int EN_SEL_LO = 0;
   localparam logic [15:0] ENABLES_RW_MASK = 16'hFFBF;
   localparam logic [15:0] FLAGS_MASK = 16'hFFB0;
   // flag register fields share positions with the enables
   localparam int FL_SHARED = 15;
   localparam int FL_CMP_LO = 11;
   localparam int FL_CAP_LO = 8;
   localparam int FL_OVF = 7;
   localparam int FL_ACC_OVF = 5;
   localparam int FL_ACC_IN = 4;
   // force register: force bits at [15:11]
   localparam int FORCE_LO = 11;
   // accumulator control: shared channel select bit
   localparam int ACC_SHARED_SEL = 10;
   localparam int ACC_ENABLE = 14;
   localparam logic [7:0] ACC_WRAP = 8'hFF;
   localparam logic [15:0] COUNTER_WRAP = 16'hFFFF;
   localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
   // prescaler
   localparam int PRESCALE_W = 9;
   localparam logic [2:0] SEL_EXTERNAL = 3'h7;
   localparam int SEL_TAP_BASE = 1; // code 0 is divide by 4 = bit 1 of the prescaler
endpackage

// ==== verif/tip_timer_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module tip_timer_asserts #(
   parameter int CMP_N = 5,
   parameter int CAP_N = 4
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   input wire logic [15:0] rdata_o,
   input wire logic ext_clock_i,
   input wire logic accum_input_i,
   input wire logic [CAP_N-1:0] capture_pins_i,
   input wire logic [CMP_N-1:0] compare_pins_o,
   input wire logic irq_o
);
   logic [15:0] en_q;
   logic [3:0] en_age;
   logic en_wr;
   logic rd_flags;
   assign en_wr = write_i && addr_i == tip_pkg::ADDR_ENABLES;
   assign rd_flags = read_i && addr_i == tip_pkg::ADDR_FLAGS;
   // shadow of the enables, rebuilt from the bus writes
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         en_q <= 16'h0000;
      end else if (en_wr) begin
         en_q <= wdata_i & tip_pkg::ENABLES_RW_MASK;
      end
   end
   // saturating age so the pin has settled after any enable change
   always_ff @(posedge clock_i) begin
      if (reset_i || en_wr) begin
         en_age <= 4'h0;
      end else if (en_age != 4'hF) begin
         en_age <= en_age + 4'h1;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // flags are read back one cycle after the strobe
   sequence s_flag_read;
      rd_flags ##1 1'b1;
   endsequence
   property p_gate(logic [15:0] m);
      s_flag_read |-> !(|(rdata_o & $past(en_q) & m)) || $past(irq_o);
   endproperty
   a_shared_irq: assert property (p_gate(16'h8000))
      else $error("shared flag enabled but no interrupt");
   a_compare_irq: assert property (p_gate(16'h7800))
      else $error("compare flag enabled but no interrupt");
   a_capture_irq: assert property (p_gate(16'h0700))
      else $error("capture flag enabled but no interrupt");
   a_wrap_irq: assert property (p_gate(16'h0080))
      else $error("wrap flag enabled but no interrupt");
   a_accum_ovf_irq: assert property (p_gate(16'h0020))
      else $error("accumulator overflow enabled but no interrupt");
   a_accum_in_irq: assert property (p_gate(16'h0010))
      else $error("accumulator input enabled but no interrupt");
   a_irq_exact: assert property (s_flag_read |->
      $past(irq_o) == |(rdata_o & $past(en_q) & tip_pkg::FLAGS_MASK))
      else $error("interrupt level differs from enabled flags");
   a_clock_out_four: assert property ((en_age == 4'hF && en_q[3:0] == 4'h8 &&
      $changed(compare_pins_o[0])) |-> $past(compare_pins_o[0]) == $past(compare_pins_o[0], 2)
      && $past(compare_pins_o[0], 2) != $past(compare_pins_o[0], 3))
      else $error("clock out pin is not a divide by four square wave");
   a_divide_sixteen: assert property ((en_age == 4'hF && en_q[3:0] == 4'hA &&
      $changed(compare_pins_o[0])) |-> $past(compare_pins_o[0]) == $past(compare_pins_o[0], 7)
      && $past(compare_pins_o[0], 8) != $past(compare_pins_o[0], 9))
      else $error("clock out pin is not a divide by sixteen square wave");
endmodule
bind tip_timer tip_timer_asserts #(.CMP_N(CMP_N), .CAP_N(CAP_N)) tip_timer_asserts_i (
   .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .ext_clock_i(ext_clock_i),
   .accum_input_i(accum_input_i), .capture_pins_i(capture_pins_i),
   .compare_pins_o(compare_pins_o), .irq_o(irq_o));
`default_nettype wire

// ==== verif/tip_timer_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tip_timer_tb_top;
   logic clock_i, reset_i, write_i, read_i, ext_clock_i, accum_input_i, irq_o, p;
   logic [7:0] addr_i;
   logic [15:0] wdata_i, rdata_o, v, d;
   logic [3:0] capture_pins_i;
   logic [4:0] compare_pins_o;
   integer fails, checks_done, seed, i, n, flags_m;
   tip_timer tip_timer_i (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
      .ext_clock_i(ext_clock_i), .accum_input_i(accum_input_i),
      .capture_pins_i(capture_pins_i), .compare_pins_o(compare_pins_o), .irq_o(irq_o));
   always #5 clock_i = ~clock_i;
   task stop_test;
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // range compare, so prescaler phase slack is allowed where needed
   task chk(input logic [15:0] got, input integer lo, input integer hi);
      checks_done = checks_done + 1;
      if (^got === 1'bx || got < lo || got > hi) begin
         fails = fails + 1;
         $display("unexpected at %0t: got %h want %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] dd);
      addr_i <= a;
      wdata_i <= dd;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task rd(input logic [7:0] a, output logic [15:0] q);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 q = rdata_o;
      @(posedge clock_i);
   endtask
   // irq is combinational from registers, so look once they settle
   task look_irq(input integer e);
      #1 chk({15'h0000, irq_o}, e, e);
      @(posedge clock_i);
   endtask
   task count_pin(input integer cyc);
      n = 0;
      p = compare_pins_o[0];
      repeat (cyc) begin
         @(posedge clock_i);
         #1 if (compare_pins_o[0] !== p) n = n + 1;
         p = compare_pins_o[0];
      end
      @(posedge clock_i);
   endtask
   initial begin
      #200000 fails = fails + 1;
      stop_test;
   end
   initial begin
      clock_i = 0; reset_i = 1; addr_i = 0; wdata_i = 0; write_i = 0; read_i = 0;
      ext_clock_i = 0; accum_input_i = 0; capture_pins_i = 0;
      fails = 0; checks_done = 0; seed = 86622; flags_m = 0;
      repeat (10) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      rd(tip_pkg::ADDR_FLAGS, v); chk(v, 0, 0);
      rd(tip_pkg::ADDR_COMPARE1, v); chk(v, 16'hFFFF, 16'hFFFF);
      rd(8'hFC, v); chk(v, 0, 0);
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         wr(tip_pkg::ADDR_ENABLES, d);
         rd(tip_pkg::ADDR_ENABLES, v); chk(v, d & tip_pkg::ENABLES_RW_MASK, d & tip_pkg::ENABLES_RW_MASK);
      end
      // eight divided ticks in a window of eight periods
      for (i = 0; i < 7; i++) begin
         wr(tip_pkg::ADDR_ENABLES, i[15:0]);
         wr(tip_pkg::ADDR_COUNTER, 16'h0000);
         repeat ((8 << (i + 2)) - 2) @(posedge clock_i);
         rd(tip_pkg::ADDR_COUNTER, v); chk(v, 7, 9);
      end
      wr(tip_pkg::ADDR_ENABLES, 16'h0007);
      wr(tip_pkg::ADDR_COUNTER, 16'h0000);
      repeat (8) begin
         repeat (3) @(posedge clock_i);
         ext_clock_i <= 1'b1;
         repeat (3) @(posedge clock_i);
         ext_clock_i <= 1'b0;
      end
      repeat (6) @(posedge clock_i);
      rd(tip_pkg::ADDR_COUNTER, v); chk(v, 8, 8);
      wr(tip_pkg::ADDR_ENABLES, 16'h0008);
      repeat (20) @(posedge clock_i);
      count_pin(64); chk(n[15:0], 31, 33);
      wr(tip_pkg::ADDR_ENABLES, 16'h000A);
      repeat (20) @(posedge clock_i);
      count_pin(64); chk(n[15:0], 7, 9);
      wr(tip_pkg::ADDR_ENABLES, 16'h0000);
      repeat (20) @(posedge clock_i);
      count_pin(64); chk(n[15:0], 0, 0);
      p = compare_pins_o[0];
      wr(tip_pkg::ADDR_FORCE, 16'h0800);
      #1 chk({15'h0000, compare_pins_o[0]}, !p, !p);
      @(posedge clock_i);
      rd(tip_pkg::ADDR_FLAGS, v); chk(v, 0, 0);
      // raise every event with all enables off
      wr(tip_pkg::ADDR_ACCUM_CTRL, 16'h4400);
      wr(tip_pkg::ADDR_ACCUM_COUNT, 16'h00FF);
      for (i = 0; i < 4; i++) wr(tip_pkg::ADDR_COMPARE1 + 8'(i * 4), 16'hFFF4);
      wr(tip_pkg::ADDR_COUNTER, 16'hFFF0);
      capture_pins_i <= 4'hF;
      accum_input_i <= 1'b1;
      repeat (120) @(posedge clock_i);
      flags_m = tip_pkg::FLAGS_MASK;
      rd(tip_pkg::ADDR_FLAGS, v); chk(v, flags_m, flags_m);
      // channels 1..4 toggled once on the match, the shared pin idles in capture mode
      chk({11'h000, compare_pins_o}, 14, 14);
      look_irq(0);
      for (i = 4; i < 16; i++) begin
         if (tip_pkg::FLAGS_MASK[i]) begin
            wr(tip_pkg::ADDR_ENABLES, 16'h0001 << i);
            rd(tip_pkg::ADDR_FLAGS, v);
            look_irq(1);
         end
      end
      // write one to clear, checked against the model
      repeat (6) begin
         d = $random(seed);
         wr(tip_pkg::ADDR_ENABLES, d);
         wr(tip_pkg::ADDR_FLAGS, d);
         flags_m = flags_m & ~d;
         rd(tip_pkg::ADDR_FLAGS, v); chk(v, flags_m, flags_m);
         look_irq(|(flags_m & d & tip_pkg::ENABLES_RW_MASK));
      end
      stop_test;
   end
endmodule
`default_nettype wire

// ==== verilog/tip_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none
// free-running system clock prescaler, one-cycle tick per tap period
module tip_prescaler #(
   parameter int WIDTH = tip_pkg::PRESCALE_W
) (
   input wire logic clock_i,
   input wire logic reset_i,
   output logic [WIDTH-1:0] count_o,
   output logic [WIDTH-1:0] tick_o
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   assign next_count = count + 1'b1;

   // counter runs every cycle; taps derive from its carry chain
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // tick bit k pulses once every 2^(k+1) cycles, when bits [k:0] roll over
   genvar k;
   generate
      for (k = 0; k < WIDTH; k++) begin : g_tap
         assign tick_o[k] = &count[k:0];
      end
   endgenerate

   assign count_o = count;
endmodule
`default_nettype wire

// ==== verilog/tip_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser with rising/falling edge outputs taken from stage two
module tip_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] stage_old;

   // only stage two reads stage one, so metastability stays contained
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         stage_one <= '0;
         stage_two <= '0;
         stage_old <= '0;
      end else begin
         stage_one <= async_i;
         stage_two <= stage_one;
         stage_old <= stage_two;
      end
   end

   assign level_o = stage_two;
   assign rise_o = stage_two & ~stage_old;
   assign fall_o = ~stage_two & stage_old;
endmodule
`default_nettype wire

// ==== verilog/tip_timer.sv ====
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tip_timer #(
   parameter int CMP_N = 5,
   parameter int CAP_N = 4
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [15:0] rdata_o,
   input wire logic ext_clock_i,
   input wire logic accum_input_i,
   input wire logic [CAP_N-1:0] capture_pins_i,
   output logic [CMP_N-1:0] compare_pins_o,
   output logic irq_o
);
   logic [15:0] timer_interrupt_enables;
   logic [15:0] timer_event_flags;
   logic [15:0] accumulator_control_reg;
   logic [15:0] free_running_counter;
   logic [7:0] accum_count;
   logic [15:0] compare_value [CMP_N];
   logic [15:0] capture_value [CAP_N];
   logic [CMP_N-1:0] compare_level;
   logic [8:0] pre_count;
   logic [8:0] pre_tick;
   logic [1:0] ext_level;
   logic [1:0] ext_rise;
   logic [1:0] ext_fall;
   logic [CAP_N-1:0] cap_level;
   logic [CAP_N-1:0] cap_rise;
   logic [CAP_N-1:0] cap_fall;
   logic counter_tick;
   logic counter_clock;
   logic counter_wrap_event;
   logic accum_ovf_event;
   logic accum_in_event;
   logic shared_is_capture;
   logic [CMP_N-1:0] compare_hit;
   logic [CAP_N-1:0] capture_hit;
   logic [15:0] set_flags;
   logic [15:0] clear_flags;
   logic [CMP_N-1:0] force_bits;
   logic [2:0] counter_clock_select;

   tip_prescaler #(
      .WIDTH(tip_pkg::PRESCALE_W)
   ) u_prescaler (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .count_o(pre_count),
      .tick_o(pre_tick)
   );

   // external clock and accumulator pin share one synchroniser
   tip_sync #(
      .WIDTH(2)
   ) u_sync_ext (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i({accum_input_i, ext_clock_i}),
      .level_o(ext_level),
      .rise_o(ext_rise),
      .fall_o(ext_fall)
   );

   tip_sync #(
      .WIDTH(CAP_N)
   ) u_sync_cap (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i(capture_pins_i),
      .level_o(cap_level),
      .rise_o(cap_rise),
      .fall_o(cap_fall)
   );

   assign counter_clock_select = timer_interrupt_enables[tip_pkg::EN_SEL_LO +: 3];
   assign shared_is_capture = accumulator_control_reg[tip_pkg::ACC_SHARED_SEL];

   // counter increment source
   always_comb begin
      if (counter_clock_select == tip_pkg::SEL_EXTERNAL) begin
         counter_tick = ext_rise[0];
         counter_clock = ext_level[0];
      end else begin
         // tap 4 to 256 by code
         counter_tick = pre_tick[counter_clock_select + 3'(tip_pkg::SEL_TAP_BASE)];
         counter_clock = pre_count[counter_clock_select + 3'(tip_pkg::SEL_TAP_BASE)];
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         free_running_counter <= '0;
      end else if (write_i && addr_i == tip_pkg::ADDR_COUNTER) begin
         free_running_counter <= wdata_i;
      end else if (counter_tick) begin
         free_running_counter <= free_running_counter + 16'h0001;
      end
   end

   assign counter_wrap_event = counter_tick && free_running_counter == tip_pkg::COUNTER_WRAP;

   // accumulator counts rising edges on its pin while enabled
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         accum_count <= '0;
      end else if (write_i && addr_i == tip_pkg::ADDR_ACCUM_COUNT) begin
         accum_count <= wdata_i[7:0];
      end else if (accum_in_event) begin
         accum_count <= accum_count + 8'h01;
      end
   end

   assign accum_in_event = accumulator_control_reg[tip_pkg::ACC_ENABLE] && ext_rise[1];
   assign accum_ovf_event = accum_in_event && accum_count == tip_pkg::ACC_WRAP;

   // compare values and matches; the last compare channel is the shared one
   genvar c;
   generate
      for (c = 0; c < CMP_N; c++) begin : g_cmp
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               compare_value[c] <= tip_pkg::COMPARE_RESET;
            end else if (write_i &&
                  addr_i == tip_pkg::ADDR_COMPARE1 + 8'(c) * tip_pkg::ADDR_COMPARE_STRIDE) begin
               compare_value[c] <= wdata_i;
            end else if (c == CMP_N - 1 && shared_is_capture && capture_hit[CAP_N-1]) begin
               compare_value[c] <= free_running_counter; // shared register latches capture
            end
         end
         // shared channel compares only in compare mode
         if (c == CMP_N - 1) begin : g_shared
            assign compare_hit[c] = !shared_is_capture && counter_tick &&
               free_running_counter == compare_value[c];
         end else begin : g_plain
            assign compare_hit[c] = counter_tick && free_running_counter == compare_value[c];
         end
         // force toggles the pin, flag untouched
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               compare_level[c] <= 1'b0;
            end else if (compare_hit[c] || force_bits[c]) begin
               compare_level[c] <= ~compare_level[c];
            end
         end
      end
   endgenerate

   assign force_bits = (write_i && addr_i == tip_pkg::ADDR_FORCE) ?
      wdata_i[tip_pkg::FORCE_LO +: CMP_N] : '0;

   // capture edges on the synchronised pins; the last is the shared channel
   genvar p;
   generate
      for (p = 0; p < CAP_N; p++) begin : g_cap
         if (p == CAP_N - 1) begin : g_shared
            // shared channel captures only in capture mode
            assign capture_hit[p] = shared_is_capture && (cap_rise[p] || cap_fall[p]);
         end else begin : g_plain
            assign capture_hit[p] = cap_rise[p] || cap_fall[p];
         end
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               capture_value[p] <= tip_pkg::COMPARE_RESET;
            end else if (capture_hit[p]) begin
               capture_value[p] <= free_running_counter;
            end
         end
      end
   endgenerate

   // counter clock replaces first compare pin
   assign compare_pins_o = timer_interrupt_enables[tip_pkg::EN_CLK_OUT] ?
      {compare_level[CMP_N-1:1], counter_clock} : compare_level;

   // enable register, reserved bit 6 held at zero
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         timer_interrupt_enables <= '0;
      end else if (write_i && addr_i == tip_pkg::ADDR_ENABLES) begin
         timer_interrupt_enables <= wdata_i & tip_pkg::ENABLES_RW_MASK;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         accumulator_control_reg <= '0;
      end else if (write_i && addr_i == tip_pkg::ADDR_ACCUM_CTRL) begin
         accumulator_control_reg <= wdata_i;
      end
   end

   // event set vector laid out like the flag register
   always_comb begin
      set_flags = '0;
      set_flags[tip_pkg::FL_SHARED] = compare_hit[CMP_N-1] || capture_hit[CAP_N-1];
      set_flags[tip_pkg::FL_CMP_LO +: 4] = compare_hit[3:0];
      set_flags[tip_pkg::FL_CAP_LO +: 3] = capture_hit[2:0];
      set_flags[tip_pkg::FL_OVF] = counter_wrap_event;
      set_flags[tip_pkg::FL_ACC_OVF] = accum_ovf_event;
      set_flags[tip_pkg::FL_ACC_IN] = accum_in_event;
   end

   assign clear_flags = (write_i && addr_i == tip_pkg::ADDR_FLAGS) ? wdata_i : '0;

   // sticky flags, write one clears, set beats clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         timer_event_flags <= '0;
      end else begin
         timer_event_flags <= ((timer_event_flags & ~clear_flags) | set_flags)
            & tip_pkg::FLAGS_MASK;
      end
   end

   // flags share enable positions, gated bitwise
   assign irq_o = |(timer_event_flags & timer_interrupt_enables & tip_pkg::FLAGS_MASK);

   // read port, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (read_i) begin
         unique case (addr_i)
            tip_pkg::ADDR_ENABLES: rdata_o <= timer_interrupt_enables;
            tip_pkg::ADDR_FLAGS: rdata_o <= timer_event_flags;
            tip_pkg::ADDR_ACCUM_CTRL: rdata_o <= accumulator_control_reg;
            tip_pkg::ADDR_COUNTER: rdata_o <= free_running_counter;
            tip_pkg::ADDR_ACCUM_COUNT: rdata_o <= {8'h00, accum_count};
            tip_pkg::ADDR_COMPARE1 + tip_pkg::ADDR_COMPARE_STRIDE:
               rdata_o <= capture_value[0];
            tip_pkg::ADDR_COMPARE1 + 8'(2) * tip_pkg::ADDR_COMPARE_STRIDE:
               rdata_o <= capture_value[1];
            tip_pkg::ADDR_COMPARE1 + 8'(3) * tip_pkg::ADDR_COMPARE_STRIDE:
               rdata_o <= capture_value[2];
            tip_pkg::ADDR_COMPARE1: rdata_o <= compare_value[0];
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end
endmodule
`default_nettype wire
